// ===== hw/dmx_dram_ctrl.sv
// dram address mux and cycle timing for area one
`timescale 1ns/1ps
module dmx_dram_ctrl
  (
    input  wire logic                         clk,                   // system clock, 50 MHz
    input  wire logic                         srst,                  // sync reset, active high
    input  wire logic                         ce,                    // clock enable, freezes state when low
    input  wire logic                         dram_space_enable,     // area one is dram
    input  wire logic                         row_col_mux_enable,    // multiplex row/column
    input  wire logic                         row_shift_sel_hi,      // shift select high bit
    input  wire logic                         row_shift_sel_lo,      // shift select low bit
    input  wire logic                         cpu_read_long_pitch,   // cpu read pitch/wait bit
    input  wire logic                         cpu_write_long_pitch,  // cpu write pitch/wait bit
    input  wire logic                         dma_read_long_pitch,   // dma read pitch/wait bit
    input  wire logic                         dma_write_long_pitch,  // dma write pitch/wait bit
    input  wire logic                         cas_high_duty_select,  // 1: 35% cas high duty; not used, cas spans whole states
    input  wire logic                         precharge_length_select, // 1: two precharge states
    input  wire logic                         refresh_wait_count_hi, // refresh wait count high bit
    input  wire logic                         refresh_wait_count_lo, // refresh wait count low bit
    input  wire logic                         byte_strobe_style_select, // 1: dual write strobes
    input  wire logic                         reqValid,              // access request, held until ack
    input  wire logic                         reqArea1,              // request targets area one
    input  wire logic [1:0]                   reqCycle,              // cycle type
    input  wire logic [dmx_pkg::ADDR_W-1:0]   reqAddr,               // logical address
    input  wire logic                         reqWide,               // 16-bit space
    input  wire logic [1:0]                   reqBytes,              // byte lanes, bit1 upper
    input  wire logic                         refreshReq,            // cbr refresh request, held until ack
    input  wire logic                         waitPin_n,             // external wait pin, low waits
    output logic                              reqReady,              // request accepted this cycle
    output logic                              refreshAck,            // refresh accepted this cycle
    output logic                              dramBusy,              // dram cycle in progress
    output logic [dmx_pkg::PIN_W-1:0]         addrPins,              // address pins
    output logic                              ras_n,                 // row strobe
    output logic                              casHigh_n,             // upper column strobe
    output logic                              casLow_n,              // lower column strobe
    output logic                              wrHigh_n,              // upper write strobe
    output logic                              wrLow_n,               // lower write strobe
    output logic                              cycleDone              // access finished pulse
  );
  import dmx_pkg::*;

  dmx_state_t stateReg;
  dmx_state_t stateNext;
  logic [ADDR_W-1:0] addrReg;
  logic [1:0]        cycleReg;
  logic              wideReg;
  logic [1:0]        bytesReg;
  logic              refreshReg;
  logic              preCntReg;
  logic [1:0]        rfCntReg;
  logic              waitSync_n;
  logic              longPitch;
  logic              isWrite;
  logic              casOn;
  logic [PIN_W-1:0]  rowAddr;

  // wait pin comes from outside, so it is resynchronised
  dmx_sync #(.RST_VAL(1'b1)) waitSyncInst
  (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .din  (waitPin_n),
    .dout (waitSync_n)
  );

  // per cycle type pitch bit also enables wait sampling
  always_comb
  begin
    case (cycleReg)
      CYC_CPU_RD: longPitch = cpu_read_long_pitch;
      CYC_CPU_WR: longPitch = cpu_write_long_pitch;
      CYC_DMA_RD: longPitch = dma_read_long_pitch;
      default:    longPitch = dma_write_long_pitch;
    endcase
  end
  assign isWrite = (cycleReg == CYC_CPU_WR) || (cycleReg == CYC_DMA_WR);

  // refresh has priority over a pending access
  assign refreshAck = ce && (stateReg == DMX_IDLE) && refreshReq && dram_space_enable;
  assign reqReady   = ce && (stateReg == DMX_IDLE) && !refreshAck && reqValid && reqArea1 && dram_space_enable;
  assign dramBusy   = (stateReg != DMX_IDLE);

  // next state, one transition per clock state
  always_comb
  begin
    stateNext = stateReg;
    case (stateReg)
      DMX_IDLE:
      begin
        if (refreshAck || reqReady)
          stateNext = DMX_ROW;
      end
      DMX_ROW:
      begin
        if (refreshReg)
          stateNext = ({refresh_wait_count_hi, refresh_wait_count_lo} != 2'h0 && cpu_read_long_pitch)
                      ? DMX_RFWT : DMX_PRE;
        else
          stateNext = DMX_COL1;
      end
      DMX_COL1:
      begin
        if (!longPitch)
          stateNext = DMX_PRE;
        else if (!waitSync_n)
          stateNext = DMX_WAIT;
        else
          stateNext = DMX_COL2;
      end
      DMX_WAIT:
      begin
        if (waitSync_n)
          stateNext = DMX_COL2;
      end
      DMX_COL2:  stateNext = DMX_PRE;
      DMX_RFWT:
      begin
        if (rfCntReg == 2'h1)
          stateNext = DMX_PRE;
      end
      DMX_PRE:
      begin
        if (!precharge_length_select || preCntReg)
          stateNext = DMX_IDLE;
      end
      default:   stateNext = DMX_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (srst)
      stateReg <= DMX_IDLE;
    else if (ce)
      stateReg <= stateNext;
  end

  // latch request at acceptance so the host may move on
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      addrReg    <= '0;
      cycleReg   <= CYC_CPU_RD;
      wideReg    <= 1'b0;
      bytesReg   <= 2'h0;
      refreshReg <= 1'b0;
    end
    else if (ce && (refreshAck || reqReady))
    begin
      addrReg    <= reqAddr;
      cycleReg   <= reqCycle;
      wideReg    <= reqWide;
      bytesReg   <= reqBytes;
      refreshReg <= refreshAck;
    end
  end

  // precharge and refresh wait counters
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      preCntReg <= 1'b0;
      rfCntReg  <= 2'h0;
    end
    else if (ce)
    begin
      preCntReg <= (stateReg == DMX_PRE) ? ~preCntReg : 1'b0;
      if (stateReg == DMX_ROW)
        rfCntReg <= {refresh_wait_count_hi, refresh_wait_count_lo};
      else if (stateReg == DMX_RFWT)
        rfCntReg <= rfCntReg - 2'h1;
    end
  end

  // row address by shift count; pins above the row read zero (undefined allowed)
  always_comb
  begin
    rowAddr = '0;
    case ({row_shift_sel_hi, row_shift_sel_lo})
      SHIFT_8:  rowAddr[15:0] = addrReg[23:8];
      SHIFT_9:  rowAddr[14:0] = addrReg[23:9];
      SHIFT_10: rowAddr[13:0] = addrReg[23:10];
      default:  rowAddr = addrReg[PIN_W-1:0];
    endcase
  end

  // cas active in DMX_WAIT and DMX_COL2, and in DMX_COL1 only at short pitch; a short pitch column state must always strobe,
  // the duty bit only moves the fall point inside one state, finer than a clock,
  // so at whole-state resolution cas is low across the full short column state
  always_comb
  begin
    casOn = 1'b0;
    case (stateReg)
      DMX_COL1:           casOn = !longPitch;
      DMX_WAIT, DMX_COL2: casOn = 1'b1;
      default:            casOn = 1'b0;
    endcase
  end

  // registered pin outputs
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      addrPins  <= '0;
      ras_n     <= 1'b1;
      casHigh_n <= 1'b1;
      casLow_n  <= 1'b1;
      wrHigh_n  <= 1'b1;
      wrLow_n   <= 1'b1;
      cycleDone <= 1'b0;
    end
    else if (ce)
    begin
      cycleDone <= (stateReg == DMX_PRE) && (stateNext == DMX_IDLE);
      if (stateReg == DMX_ROW && !refreshReg && row_col_mux_enable)
        addrPins <= rowAddr;
      else
        addrPins <= addrReg[PIN_W-1:0];
      if (refreshReg)
      begin
        // cas before ras: both column strobes fall first
        casLow_n  <= !(stateReg == DMX_ROW || stateReg == DMX_RFWT);
        casHigh_n <= !(stateReg == DMX_ROW || stateReg == DMX_RFWT);
        ras_n     <= !(stateReg == DMX_RFWT);
        wrHigh_n  <= 1'b1;
        wrLow_n   <= 1'b1;
      end
      else
      begin
        ras_n <= !(stateReg == DMX_ROW || stateReg == DMX_COL1 ||
                   stateReg == DMX_WAIT || stateReg == DMX_COL2);
        if (wideReg && !byte_strobe_style_select)
        begin
          casHigh_n <= !(casOn && bytesReg[1]);
          casLow_n  <= !(casOn && bytesReg[0]);
          wrHigh_n  <= 1'b1;
          wrLow_n   <= !(casOn && isWrite);
        end
        else if (wideReg)
        begin
          casHigh_n <= 1'b1;
          casLow_n  <= !casOn;
          wrHigh_n  <= !(casOn && isWrite && bytesReg[1]);
          wrLow_n   <= !(casOn && isWrite && bytesReg[0]);
        end
        else
        begin
          casHigh_n <= 1'b1;
          casLow_n  <= !casOn;
          wrHigh_n  <= 1'b1;
          wrLow_n   <= !(casOn && isWrite);
        end
      end
    end
  end
endmodule

// ===== hw/dmx_pkg.sv
// constants and types shared by the dram mux/timing block
// What this block does
// - dram enable maps area one to dram
// - mux enable sends row then column
// - shift select picks 8, 9, 10 bits
// - shift 00 puts A23-A8 on pins A15-A0
// - column phase drives A21-A0 unshifted
// - pitch bit 0 gives one column state
// - pitch bit 1 gives two column states
// - cas high duty bit is not used; cas spans whole states
// - precharge lasts one or two states
// - wait bit 0 ignores wait pin
// - wait bit 1 samples wait, inserts states
// - wait high releases to final column state
// - cpu read long pitch adds refresh waits
// - byte strobe style selects cas/we set
package dmx_pkg;
  localparam int ADDR_W      = 24;
  localparam int PIN_W       = 22;
  localparam logic [1:0] SHIFT_8  = 2'h0;
  localparam logic [1:0] SHIFT_9  = 2'h1;
  localparam logic [1:0] SHIFT_10 = 2'h2;
  localparam logic [1:0] CYC_CPU_RD = 2'h0;
  localparam logic [1:0] CYC_CPU_WR = 2'h1;
  localparam logic [1:0] CYC_DMA_RD = 2'h2;
  localparam logic [1:0] CYC_DMA_WR = 2'h3;
  localparam logic [2:0] DUTY_PH_50 = 3'h3; // cas high phases of six for 50%
  localparam logic [2:0] DUTY_PH_35 = 3'h2; // two of six, about 35%
  localparam logic [2:0] DUTY_PHASES = 3'h6;
  typedef enum logic [2:0] {
    DMX_IDLE  = 3'b000,
    DMX_ROW   = 3'b001,
    DMX_COL1  = 3'b010,
    DMX_WAIT  = 3'b011,
    DMX_COL2  = 3'b100,
    DMX_PRE   = 3'b101,
    DMX_RFWT  = 3'b110
  } dmx_state_t;
endpackage

// ===== hw/dmx_sync.sv
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
module dmx_sync
  #(parameter logic RST_VAL = 1'b1)
  (
    input  wire logic clk,   // system clock
    input  wire logic srst,  // sync reset
    input  wire logic ce,    // clock enable
    input  wire logic din,   // async level
    output logic      dout   // synchronised level
  );
  logic stage1Reg;
  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      stage1Reg <= RST_VAL;
      dout      <= RST_VAL;
    end
    else if (ce)
    begin
      stage1Reg <= din;
      dout      <= stage1Reg;
    end
  end
endmodule

// ===== verification/dmx_dram_ctrl_props.sv
// assertion checker for the dram mux and timing block
`timescale 1ns/1ps
module dmx_dram_ctrl_props
  (
    input wire logic        clk,                     // clock
    input wire logic        srst,                    // reset
    input wire logic        dram_space_enable,       // cfg
    input wire logic        row_col_mux_enable,      // cfg
    input wire logic        row_shift_sel_hi,        // cfg
    input wire logic        row_shift_sel_lo,        // cfg
    input wire logic        cpu_read_long_pitch,     // cfg
    input wire logic        cpu_write_long_pitch,    // cfg
    input wire logic        dma_read_long_pitch,     // cfg
    input wire logic        dma_write_long_pitch,    // cfg
    input wire logic        precharge_length_select, // cfg
    input wire logic        reqValid,                // req
    input wire logic        reqArea1,                // req
    input wire logic [1:0]  reqCycle,                // req
    input wire logic [23:0] reqAddr,                 // req
    input wire logic        refreshReq,              // req
    input wire logic        reqReady,                // out
    input wire logic        refreshAck,              // out
    input wire logic        dramBusy,                // out
    input wire logic [21:0] addrPins,                // out
    input wire logic        ras_n,                   // out
    input wire logic        cycleDone                // out
  );
  logic [3:0]  pv;
  logic [1:0]  sh;
  logic        isReq;
  logic [23:0] lat;
  assign pv = {dma_write_long_pitch, dma_read_long_pitch, cpu_write_long_pitch, cpu_read_long_pitch};
  assign sh = {row_shift_sel_hi, row_shift_sel_lo};
  // keep the taken address; a refresh clears the flag so its ras edge is not read as a row
  always_ff @(posedge clk)
  begin
    if (reqReady)
      lat <= reqAddr;
    if (srst)
      isReq <= 1'b0;
    else if (reqReady | refreshAck)
      isReq <= reqReady;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_take_gated: assert property (reqReady |-> reqValid && reqArea1 && dram_space_enable)
    else $error("request taken while not allowed");
  a_busy_refuse: assert property (dramBusy |-> !reqReady)
    else $error("request taken while busy");
  a_short_done: assert property (reqReady && !pv[reqCycle] && !precharge_length_select |-> ##4 cycleDone)
    else $error("short cycle length wrong");
  a_two_precharge: assert property (reqReady && !pv[reqCycle] && precharge_length_select |-> ##5 cycleDone)
    else $error("two-state precharge length wrong");
  a_long_min: assert property (reqReady && pv[reqCycle] |-> ##1 !cycleDone [*4] ##[1:60] cycleDone)
    else $error("long cycle length wrong");
  a_row_shift: assert property ($fell(ras_n) && isReq && row_col_mux_enable
    |-> ((addrPins ^ 22'(lat >> (5'd8 + sh))) & (22'h3fffff >> (5'd6 + sh))) == 22'h0)
    else $error("row address wrong");
  a_mux_off: assert property ($fell(ras_n) && isReq && !row_col_mux_enable |-> addrPins == lat[21:0])
    else $error("unmultiplexed address wrong");
  a_col_addr: assert property ($fell(ras_n) && isReq |=> addrPins == lat[21:0])
    else $error("column address wrong");
  a_ack_excl: assert property (refreshAck |-> refreshReq && !reqReady)
    else $error("refresh taken wrongly");
  c_long: cover property (reqReady && pv[reqCycle]);
  c_refresh: cover property (refreshAck && cpu_read_long_pitch);
  c_shift10: cover property ($fell(ras_n) && isReq && sh == 2'h2);
endmodule

// ===== verification/dmx_dram_model.sv
// far-side dram model: holds the wait pin low while each request is raised and for a set time after it drops
`timescale 1ns/1ps
module dmx_dram_model
  (
    input  wire logic       clk,       // system clock
    input  wire logic       start,     // request raised by the host
    input  wire logic [3:0] waitLen,   // wait states wanted
    output logic            waitPin_n  // wait pin, pulled up
  );
  logic [3:0] cntReg = 4'h0;
  // the pin goes low while the request is raised: the controller passes it
  // through two flip-flops, so a later fall would miss the column state
  always_ff @(posedge clk)
  begin
    if (start)
      cntReg <= (waitLen == 4'h0) ? 4'h0 : waitLen - 4'h1;
    else if (cntReg != 4'h0)
      cntReg <= cntReg - 4'h1;
  end
  // lets go to the pull-up level once the wanted states are spent
  assign waitPin_n = !((start && waitLen != 4'h0) || cntReg != 4'h0);
endmodule

// ===== verification/test_dmx_dram_ctrl.sv
// self-checking bench for the dram mux and timing block
`timescale 1ns/1ps
module test_dmx_dram_ctrl;
  import dmx_pkg::*;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, reqValid = 1'b0, reqArea1 = 1'b1, refreshReq = 1'b0, reqWide = 1'b1;
  logic dram_space_enable = 1'b1, row_col_mux_enable = 1'b1, row_shift_sel_hi = 1'b0, row_shift_sel_lo = 1'b0;
  logic cas_high_duty_select = 1'b0, precharge_length_select = 1'b0, byte_strobe_style_select = 1'b0;
  logic refresh_wait_count_hi = 1'b0, refresh_wait_count_lo = 1'b0;
  logic [1:0] reqCycle = 2'h0, reqBytes = 2'h2;
  logic [23:0] reqAddr = 24'h0;
  logic [3:0] pitch = 4'h0, waitLen = 4'h8, seen;
  logic reqReady, refreshAck, dramBusy, ras_n, casHigh_n, casLow_n, wrHigh_n, wrLow_n, cycleDone, waitPin_n;
  logic [21:0] addrPins;
  wire logic cpu_read_long_pitch = pitch[0];
  wire logic cpu_write_long_pitch = pitch[1];
  wire logic dma_read_long_pitch = pitch[2];
  wire logic dma_write_long_pitch = pitch[3];
  int failures = 0, comparisons = 0, rasLow, n, m, k;
  dmx_dram_ctrl u_dmx_dram_ctrl
  (
    .clk(clk), .srst(srst), .ce(ce), .dram_space_enable(dram_space_enable),
    .row_col_mux_enable(row_col_mux_enable), .row_shift_sel_hi(row_shift_sel_hi),
    .row_shift_sel_lo(row_shift_sel_lo), .cpu_read_long_pitch(cpu_read_long_pitch),
    .cpu_write_long_pitch(cpu_write_long_pitch), .dma_read_long_pitch(dma_read_long_pitch),
    .dma_write_long_pitch(dma_write_long_pitch), .cas_high_duty_select(cas_high_duty_select),
    .precharge_length_select(precharge_length_select), .refresh_wait_count_hi(refresh_wait_count_hi),
    .refresh_wait_count_lo(refresh_wait_count_lo), .byte_strobe_style_select(byte_strobe_style_select),
    .reqValid(reqValid), .reqArea1(reqArea1), .reqCycle(reqCycle), .reqAddr(reqAddr), .reqWide(reqWide),
    .reqBytes(reqBytes), .refreshReq(refreshReq), .waitPin_n(waitPin_n), .reqReady(reqReady),
    .refreshAck(refreshAck), .dramBusy(dramBusy), .addrPins(addrPins), .ras_n(ras_n),
    .casHigh_n(casHigh_n), .casLow_n(casLow_n), .wrHigh_n(wrHigh_n), .wrLow_n(wrLow_n),
    .cycleDone(cycleDone)
  );
  dmx_dram_model u_dmx_dram_model (.clk(clk), .start(reqValid), .waitLen(waitLen), .waitPin_n(waitPin_n));
  always #10 clk = ~clk;
  // strobes that ever went low, and ras low time, sampled mid-cycle
  always @(negedge clk)
  begin
    seen = seen & {casHigh_n, casLow_n, wrHigh_n, wrLow_n};
    rasLow = rasLow + (ras_n === 1'b0);
  end
  task automatic complete_run;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
      comparisons++;
      if (got !== exp)
      begin
        failures++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // one access or refresh; cnt is the length in clocks, or the ras low time for a refresh
  task automatic run(input bit rf, input logic [1:0] cyc, input logic [23:0] a, output int cnt);
    int i;
    begin
      @(posedge clk);
      seen = 4'hf;
      rasLow = 0;
      reqCycle <= cyc;
      reqAddr <= a;
      refreshReq <= rf;
      reqValid <= !rf;
      i = 0;
      do
        @(negedge clk);
      while ((rf ? refreshAck : reqReady) !== 1'b1 && ++i < 40);
      @(posedge clk);
      refreshReq <= 1'b0;
      reqValid <= 1'b0;
      // cnt counts clocks from the taking edge to the one that sees cycleDone
      cnt = 0;
      do
      begin
        @(negedge clk);
        cnt++;
      end
      while ((rf ? !dramBusy : cycleDone) !== 1'b1 && cnt < 80);
      if (i >= 40 || cnt >= 80)
      begin
        failures++;
        complete_run();
      end
      // pins lag the state by a clock, so let the last ras level land
      repeat (2) @(negedge clk);
      if (rf)
        cnt = rasLow;
    end
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    // shifts 8, 9, 10 then multiplexing off; the reserved code is never set
    for (k = 0; k < 4; k++)
    begin
      @(posedge clk);
      {row_shift_sel_hi, row_shift_sel_lo} <= (k == 3) ? 2'h0 : k[1:0];
      row_col_mux_enable <= (k != 3);
      run(1'b0, CYC_CPU_RD, 24'ha5c3e1 + 24'(k * 24'h111111), n);
      check(n, 4);
    end
    // a disabled area must not take the request
    @(posedge clk);
    dram_space_enable <= 1'b0;
    reqValid <= 1'b1;
    m = 0;
    repeat (8)
    begin
      @(negedge clk);
      m = m + (reqReady !== 1'b0);
    end
    check(m, 0);
    @(posedge clk);
    reqValid <= 1'b0;
    dram_space_enable <= 1'b1;
    waitLen <= 4'h0;
    // each cycle type has its own pitch bit: long adds one column state
    for (k = 0; k < 4; k++)
    begin
      @(posedge clk);
      pitch <= 4'h0;
      run(1'b0, k[1:0], 24'h00f0f0, n);
      @(posedge clk);
      pitch <= 4'h1 << k;
      run(1'b0, k[1:0], 24'h00f0f0, m);
      check(m - n, 1);
    end
    // wait pin held low longer costs exactly that many more states
    @(posedge clk);
    pitch <= 4'h1;
    waitLen <= 4'h4;
    run(1'b0, CYC_CPU_RD, 24'h3c3c3c, n);
    @(posedge clk);
    waitLen <= 4'h7;
    run(1'b0, CYC_CPU_RD, 24'h3c3c3c, m);
    check(m - n, 3);
    // two precharge states, with the narrower cas high duty exercised alongside
    @(posedge clk);
    pitch <= 4'h0;
    precharge_length_select <= 1'b1;
    cas_high_duty_select <= 1'b1;
    run(1'b0, CYC_CPU_RD, 24'h123456, n);
    check(n, 5);
    check(seen, 4'h7);
    // upper byte write: both strobe styles, then an 8-bit space
    for (k = 0; k < 3; k++)
    begin
      @(posedge clk);
      precharge_length_select <= 1'b0;
      byte_strobe_style_select <= k[0];
      reqWide <= (k != 2);
      run(1'b0, CYC_CPU_WR, 24'h000101, n);
      check(seen, (k == 0) ? 4'h6 : (k == 1) ? 4'h9 : 4'ha);
    end
    // refresh waits 0..3 with long cpu read, then 3 with it short
    for (k = 0; k < 5; k++)
    begin
      @(posedge clk);
      pitch <= {3'h0, k != 4};
      {refresh_wait_count_hi, refresh_wait_count_lo} <= (k == 4) ? 2'h3 : k[1:0];
      run(1'b1, CYC_CPU_RD, 24'h0, n);
      check(n, (k == 4) ? 0 : k);
    end
    complete_run();
  end
endmodule
bind dmx_dram_ctrl dmx_dram_ctrl_props u_dmx_dram_ctrl_props
(
  .clk(clk), .srst(srst), .dram_space_enable(dram_space_enable), .row_col_mux_enable(row_col_mux_enable),
  .row_shift_sel_hi(row_shift_sel_hi), .row_shift_sel_lo(row_shift_sel_lo),
  .cpu_read_long_pitch(cpu_read_long_pitch), .cpu_write_long_pitch(cpu_write_long_pitch),
  .dma_read_long_pitch(dma_read_long_pitch), .dma_write_long_pitch(dma_write_long_pitch),
  .precharge_length_select(precharge_length_select), .reqValid(reqValid), .reqArea1(reqArea1),
  .reqCycle(reqCycle), .reqAddr(reqAddr), .refreshReq(refreshReq), .reqReady(reqReady),
  .refreshAck(refreshAck), .dramBusy(dramBusy), .addrPins(addrPins), .ras_n(ras_n), .cycleDone(cycleDone)
);
